// ---- lscr_config_regs.sv ----
`include "lscr_defines.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Overall ALS gain decoded from gain code, top bit and low-enable bit.
// R2: With read-clear set, a status read clears all flags.
// R3: Sleep-after-interrupt acts when an ALS or proximity cycle completes.
// R4: Oscillator off without power-on; gated by sleep bit and interrupt pin.
// R5: Interrupt pin is enabled ALS flag or enabled proximity flag.
// R6: Asleep behaves as powered off, yet power-on reads back as one.
// R7: Only clearing the status flags wakes the device from sleep; code also wakes on a cleared interrupt enable or power-on low.
// R8: Offset magnitude register at 0xC0, read-write, resets to zero.
// R9: Offset sign in bit 0 of 0xC1, upper bits reserved, reset zero.
// R10: Signed offset up to 255 applied to proximity result as generated.
// R11: Autozero interval: 00h never, n every nth, 7Fh first only.
// R12: Writing one to a status flag clears it.
// R13: Unlisted gain combinations map to nearest gain without fault.
module lscr_config_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic power_on_bit,
    input wire logic als_irq_enable,
    input wire logic prox_irq_enable,
    input wire logic [1:0] als_gain_code,
    input wire logic als_gain_top,
    input wire logic als_gain_low_enable,
    input wire logic [7:0] status_set,
    input wire logic als_cycle_done,
    input wire logic prox_cycle_done,
    input wire logic prox_raw_valid,
    input wire logic [7:0] prox_raw,
    output logic osc_enable,
    output logic irq_pin,
    output logic [8:0] als_gain_half,
    output logic autozero_now,
    output logic prox_result_valid,
    output logic [7:0] prox_result
);
    logic [7:0] misc_config;
    logic [7:0] prox_offset_mag;
    logic [7:0] prox_offset_sign_reg;
    logic [7:0] autozero_config;
    logic [7:0] status;
    lscr_pkg::lscr_osc_e osc_state;
    logic [6:0] az_count;
    logic az_first_done;
    logic irq_cond;
    logic [7:0] next_status;

    wire read_clear = misc_config[`LSCR_MISC_READ_CLEAR_BIT];
    wire sleep_after_irq = misc_config[`LSCR_MISC_SAI_BIT];
    wire [6:0] autozero_interval = autozero_config[6:0];
    wire wr_status = reg_wr && reg_addr == `LSCR_ADDR_STATUS;
    wire rd_status = reg_rd && reg_addr == `LSCR_ADDR_STATUS;

    //////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            misc_config <= `LSCR_MISC_CONFIG_RST;
            prox_offset_mag <= `LSCR_POFF_MAG_RST;
            prox_offset_sign_reg <= `LSCR_POFF_SIGN_RST;
            autozero_config <= `LSCR_AUTOZERO_CONFIG_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `LSCR_ADDR_MISC_CONFIG: misc_config <= reg_wdata;
                `LSCR_ADDR_POFF_MAG: prox_offset_mag <= reg_wdata; // R8
                `LSCR_ADDR_POFF_SIGN: prox_offset_sign_reg <= {7'h00, reg_wdata[0]}; // R9
                `LSCR_ADDR_AUTOZERO_CONFIG: autozero_config <= {1'b0, reg_wdata[6:0]};
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over any clear in the same cycle

    always_comb begin
        next_status = status;
        if (wr_status) begin
            next_status = next_status & ~reg_wdata; // R12
        end
        if (rd_status && read_clear) begin
            next_status = 8'h00; // R2
        end
        next_status = next_status | status_set;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status <= `LSCR_STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    assign irq_cond = (status[`LSCR_STATUS_ALS_IRQ_FLAG_BIT] && als_irq_enable)
        || (status[`LSCR_STATUS_PROX_IRQ_FLAG_BIT] && prox_irq_enable); // R5

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_pin <= 1'b0;
        end else begin
            irq_pin <= irq_cond;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Oscillator gating

    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_state <= lscr_pkg::LSCR_RUN;
        end else begin
            unique case (osc_state)
                lscr_pkg::LSCR_RUN: begin
                    if (power_on_bit && sleep_after_irq && irq_pin && (als_cycle_done || prox_cycle_done)) begin
                        osc_state <= lscr_pkg::LSCR_SLEEP; // R3
                    end
                end
                lscr_pkg::LSCR_SLEEP: begin
                    // Pin drop comes from flag clears or cleared enables; power-off also leaves sleep
                    if (!irq_cond || !power_on_bit) begin
                        osc_state <= lscr_pkg::LSCR_RUN; // R7
                    end
                end
                default: osc_state <= lscr_pkg::LSCR_RUN;
            endcase
        end
    end

    // Power-on reads back unchanged; only the oscillator shows the sleep
    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_enable <= 1'b0;
        end else begin
            osc_enable <= power_on_bit && (osc_state == lscr_pkg::LSCR_RUN); // R4 R6
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // ALS gain

    always_ff @(posedge core_clk) begin
        if (rst) begin
            als_gain_half <= 9'h002;
        end else if (!als_gain_low_enable) begin
            als_gain_half <= 9'h001; // R1 R13
        end else begin
            unique case (als_gain_code)
                2'b00: als_gain_half <= 9'h002; // R1
                2'b01: als_gain_half <= 9'h008;
                2'b10: als_gain_half <= 9'h020;
                2'b11: als_gain_half <= als_gain_top ? 9'h100 : 9'h080;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Autozero scheduling

    always_ff @(posedge core_clk) begin
        if (rst) begin
            az_count <= 7'h00;
            az_first_done <= 1'b0;
            autozero_now <= 1'b0;
        end else begin
            autozero_now <= 1'b0;
            if (!power_on_bit) begin
                az_first_done <= 1'b0;
                az_count <= 7'h00;
            end else if (als_cycle_done && osc_enable) begin
                az_first_done <= 1'b1;
                if (autozero_interval == `LSCR_AZ_NEVER) begin
                    autozero_now <= 1'b0; // R11
                end else if (autozero_interval == `LSCR_AZ_FIRST_ONLY) begin
                    autozero_now <= !az_first_done; // R11
                end else begin
                    autozero_now <= az_count == 7'h00; // R11
                    az_count <= (az_count + 7'h01 >= autozero_interval) ? 7'h00 : az_count + 7'h01;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Proximity offset and read mux

    lscr_prox_adjust #(
        .DATA_W(8)
    ) u_adjust (
        .core_clk(core_clk),
        .rst(rst),
        .raw_valid(prox_raw_valid),
        .raw_data(prox_raw),
        .offset_mag(prox_offset_mag),
        .offset_neg(prox_offset_sign_reg[0]),
        .result_valid(prox_result_valid),
        .result(prox_result)
    ); // R10

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LSCR_ADDR_STATUS: reg_rdata <= status;
                `LSCR_ADDR_MISC_CONFIG: reg_rdata <= misc_config;
                `LSCR_ADDR_POFF_MAG: reg_rdata <= prox_offset_mag;
                `LSCR_ADDR_POFF_SIGN: reg_rdata <= prox_offset_sign_reg;
                `LSCR_ADDR_AUTOZERO_CONFIG: reg_rdata <= autozero_config;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks

    sequence cycle_end_s;
        als_cycle_done || prox_cycle_done;
    endsequence

    sleep_entry_a: assert property (@(posedge core_clk) disable iff (rst) // R3
        (power_on_bit && sleep_after_irq && irq_pin && osc_state == lscr_pkg::LSCR_RUN) and cycle_end_s
        |=> osc_state == lscr_pkg::LSCR_SLEEP) else $error("no sleep after interrupt");
    osc_off_a: assert property (@(posedge core_clk) disable iff (rst) // R4
        !power_on_bit |=> !osc_enable) else $error("oscillator runs with power off");
    irq_pin_a: assert property (@(posedge core_clk) disable iff (rst) // R5
        irq_cond |=> irq_pin) else $error("interrupt pin missed");
    read_clear_a: assert property (@(posedge core_clk) disable iff (rst) // R2
        rd_status && read_clear && status_set == 8'h00 |=> status == 8'h00) else $error("read clear failed");
    w1c_clear_a: assert property (@(posedge core_clk) disable iff (rst) // R12
        wr_status && (status_set & reg_wdata) == 8'h00 |=> (status & $past(reg_wdata)) == 8'h00)
        else $error("write one clear failed");
    sleep_hold_a: assert property (@(posedge core_clk) disable iff (rst) // R7
        osc_state == lscr_pkg::LSCR_SLEEP && irq_cond && power_on_bit |=> osc_state == lscr_pkg::LSCR_SLEEP)
        else $error("woke without clear");
    sleep_quiet_a: assert property (@(posedge core_clk) disable iff (rst) // R6
        osc_state == lscr_pkg::LSCR_SLEEP |=> !osc_enable) else $error("oscillator on while asleep");
    sign_reserved_a: assert property (@(posedge core_clk) disable iff (rst) // R9
        prox_offset_sign_reg[7:1] == 7'h00) else $error("reserved sign bits set");
    gain_top_a: assert property (@(posedge core_clk) disable iff (rst) // R1
        als_gain_low_enable && als_gain_code == 2'b11 && als_gain_top |=> als_gain_half == 9'h100)
        else $error("gain 128 wrong");
    az_never_a: assert property (@(posedge core_clk) disable iff (rst) // R11
        autozero_interval == `LSCR_AZ_NEVER ##1 autozero_interval == `LSCR_AZ_NEVER |-> !autozero_now)
        else $error("autozero when disabled");
endmodule : lscr_config_regs

// ---- lscr_defines.svh ----
`ifndef LSCR_DEFINES_SVH
`define LSCR_DEFINES_SVH

// Register offsets
`define LSCR_ADDR_STATUS 8'h93
`define LSCR_ADDR_MISC_CONFIG 8'hAB
`define LSCR_ADDR_POFF_MAG 8'hC0
`define LSCR_ADDR_POFF_SIGN 8'hC1
`define LSCR_ADDR_AUTOZERO_CONFIG 8'hD6

// Field positions
`define LSCR_MISC_READ_CLEAR_BIT 7
`define LSCR_MISC_SAI_BIT 4
`define LSCR_STATUS_PROX_IRQ_FLAG_BIT 5
`define LSCR_STATUS_ALS_IRQ_FLAG_BIT 4

// Reset values
`define LSCR_MISC_CONFIG_RST 8'h4C
`define LSCR_POFF_MAG_RST 8'h00
`define LSCR_POFF_SIGN_RST 8'h00
`define LSCR_AUTOZERO_CONFIG_RST 8'h7F
`define LSCR_STATUS_RST 8'h00

// Autozero interval encodings
`define LSCR_AZ_NEVER 7'h00
`define LSCR_AZ_FIRST_ONLY 7'h7F

`endif

// ---- lscr_pkg.sv ----
package lscr_pkg;
    // Overall ALS gain, in half steps: 1 = x1/2 ... 256 = x128
    typedef logic [8:0] lscr_gain_t;

    typedef enum logic [1:0] {
        LSCR_RUN = 2'b01,
        LSCR_SLEEP = 2'b10
    } lscr_osc_e;
endpackage : lscr_pkg

// ---- lscr_prox_adjust.sv ----
`include "lscr_defines.svh"

module lscr_prox_adjust #(
    parameter int DATA_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    input wire logic [7:0] offset_mag,
    input wire logic offset_neg,
    output logic result_valid,
    output logic [DATA_W-1:0] result
);
    // Offset magnitude is 8 bits; narrower samples could not absorb it
    if (DATA_W < 8 || DATA_W > 16) begin : g_bad_width
        $error("lscr_prox_adjust: DATA_W out of range");
    end

    localparam int SUM_W = DATA_W + 2;
    localparam logic [SUM_W-1:0] MAX_V = SUM_W'({DATA_W{1'b1}});
    logic signed [SUM_W-1:0] sum;

    // Offset applied as the sample is produced; saturates at both ends
    always_comb begin
        if (offset_neg) begin
            sum = $signed({2'b00, raw_data}) - $signed({{(SUM_W-8){1'b0}}, offset_mag});
        end else begin
            sum = $signed({2'b00, raw_data}) + $signed({{(SUM_W-8){1'b0}}, offset_mag});
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= raw_valid;
            if (raw_valid) begin
                if (sum < 0) begin
                    result <= '0;
                end else if (sum > $signed(MAX_V)) begin
                    result <= {DATA_W{1'b1}};
                end else begin
                    result <= sum[DATA_W-1:0];
                end
            end
        end
    end
endmodule : lscr_prox_adjust

// ---- lscr_host_model.sv ----
module lscr_host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    //////////////////////////////////////////////////////////////////////////////
    // Idle bus shows inverted values so a stale address never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : lscr_host_model

// ---- tb_lscr_config_regs.sv ----
module tb_lscr_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, reg_wr, reg_rd, power_on_bit, als_irq_enable, prox_irq_enable;
    logic als_gain_top, als_gain_low_enable, als_cycle_done, prox_cycle_done, prox_raw_valid;
    logic osc_enable, irq_pin, autozero_now, prox_result_valid;
    logic [1:0] als_gain_code;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, status_set, prox_raw, prox_result, d, az_count;
    logic [8:0] als_gain_half;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    lscr_host_model u_lscr_host_model (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    lscr_config_regs u_lscr_config_regs (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_on_bit(power_on_bit),
        .als_irq_enable(als_irq_enable), .prox_irq_enable(prox_irq_enable), .als_gain_code(als_gain_code),
        .als_gain_top(als_gain_top), .als_gain_low_enable(als_gain_low_enable), .status_set(status_set),
        .als_cycle_done(als_cycle_done), .prox_cycle_done(prox_cycle_done), .prox_raw_valid(prox_raw_valid),
        .prox_raw(prox_raw), .osc_enable(osc_enable), .irq_pin(irq_pin), .als_gain_half(als_gain_half),
        .autozero_now(autozero_now), .prox_result_valid(prox_result_valid), .prox_result(prox_result));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (autozero_now === 1'b1) az_count <= az_count + 8'h01;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic set_flag(input logic [7:0] m);
        @(negedge core_clk);
        status_set = m;
        @(negedge core_clk);
        status_set = 8'h00;
    endtask : set_flag
    task automatic done_pulse(input logic is_prox);
        @(negedge core_clk);
        prox_cycle_done = is_prox;
        als_cycle_done = ~is_prox;
        @(negedge core_clk);
        prox_cycle_done = 1'b0;
        als_cycle_done = 1'b0;
    endtask : done_pulse
    task automatic prox(input logic [7:0] raw, input logic [7:0] exp);
        @(negedge core_clk);
        prox_raw_valid = 1'b1;
        prox_raw = raw;
        @(negedge core_clk);
        prox_raw_valid = 1'b0;
        prox_raw = ~raw;
        check("prox_valid", 9'(prox_result_valid), 9'h001);
        check("prox_result", 9'(prox_result), 9'(exp));
    endtask : prox
    //////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [7:0] addrs[6] = '{8'h93, 8'hAB, 8'hC0, 8'hC1, 8'hD6, 8'h55};
        logic [7:0] exps[6] = '{8'h00, 8'h4C, 8'h00, 8'h00, 8'h7F, 8'h00};
        for (int i = 0; i < 6; i++) begin
            u_lscr_host_model.rd(addrs[i], d);
            check("reset_value", 9'(d), 9'(exps[i]));
        end
        $display("test_reset done");
    endtask : test_reset
    task automatic test_gain();
        logic [3:0] cfg[7] = '{4'b0000, 4'b0001, 4'b0101, 4'b1001, 4'b1101, 4'b1111, 4'b1110};
        logic [8:0] exps[7] = '{9'h001, 9'h002, 9'h008, 9'h020, 9'h080, 9'h100, 9'h001};
        for (int i = 0; i < 7; i++) begin
            {als_gain_code, als_gain_top, als_gain_low_enable} = cfg[i];
            tick(3);
            check("gain", als_gain_half, exps[i]);
        end
        $display("test_gain done");
    endtask : test_gain
    task automatic test_offset();
        u_lscr_host_model.wr(8'hC0, 8'hFF);
        u_lscr_host_model.rd(8'hC0, d);
        check("offset_mag", 9'(d), 9'h0FF);
        u_lscr_host_model.wr(8'hC1, 8'hFF);
        u_lscr_host_model.rd(8'hC1, d);
        check("offset_sign", 9'(d), 9'h001);
        u_lscr_host_model.wr(8'hC0, 8'h14);
        prox(8'h0A, 8'h00);
        prox(8'h32, 8'h1E);
        u_lscr_host_model.wr(8'hC1, 8'h00);
        prox(8'hFA, 8'hFF);
        $display("test_offset done");
    endtask : test_offset
    task automatic test_irq();
        als_irq_enable = 1'b1;
        set_flag(8'h10);
        tick(2);
        check("irq_set", 9'(irq_pin), 9'h001);
        u_lscr_host_model.wr(8'h93, 8'h10);
        tick(2);
        check("irq_w1c", 9'(irq_pin), 9'h000);
        u_lscr_host_model.wr(8'hAB, 8'hCC);
        set_flag(8'h10);
        u_lscr_host_model.rd(8'h93, d);
        check("status_read", 9'(d), 9'h010);
        u_lscr_host_model.rd(8'h93, d);
        check("status_cleared", 9'(d), 9'h000);
        check("irq_cleared", 9'(irq_pin), 9'h000);
        als_irq_enable = 1'b0;
        $display("test_irq done");
    endtask : test_irq
    task automatic test_sleep();
        u_lscr_host_model.wr(8'hAB, 8'h5C);
        power_on_bit = 1'b1;
        prox_irq_enable = 1'b1;
        tick(3);
        check("osc_on", 9'(osc_enable), 9'h001);
        set_flag(8'h20);
        tick(3);
        check("osc_before_done", 9'(osc_enable), 9'h001);
        done_pulse(1'b1);
        tick(3);
        check("osc_sleep", 9'(osc_enable), 9'h000);
        done_pulse(1'b0);
        tick(3);
        check("osc_still_off", 9'(osc_enable), 9'h000);
        u_lscr_host_model.wr(8'h93, 8'h20);
        tick(3);
        check("osc_wake", 9'(osc_enable), 9'h001);
        power_on_bit = 1'b0;
        tick(3);
        check("osc_pwr_off", 9'(osc_enable), 9'h000);
        prox_irq_enable = 1'b0;
        $display("test_sleep done");
    endtask : test_sleep
    task automatic test_autozero();
        logic [7:0] start;
        power_on_bit = 1'b1;
        u_lscr_host_model.wr(8'hD6, 8'h00);
        tick(3);
        start = az_count;
        for (int i = 0; i < 3; i++) done_pulse(1'b0);
        tick(3);
        check("az_never", 9'(az_count - start), 9'h000);
        u_lscr_host_model.wr(8'hD6, 8'h02);
        start = az_count;
        for (int i = 0; i < 4; i++) done_pulse(1'b0);
        tick(3);
        check("az_every_2nd", 9'(az_count - start), 9'h002);
        power_on_bit = 1'b0;
        u_lscr_host_model.wr(8'hD6, 8'h7F);
        power_on_bit = 1'b1;
        tick(3);
        start = az_count;
        for (int i = 0; i < 3; i++) done_pulse(1'b0);
        tick(3);
        check("az_first_only", 9'(az_count - start), 9'h001);
        $display("test_autozero done");
    endtask : test_autozero
    initial begin
        {rst, power_on_bit, als_irq_enable, prox_irq_enable, als_gain_top} = 5'b10000;
        {als_gain_low_enable, als_cycle_done, prox_cycle_done, prox_raw_valid} = 4'b1000;
        als_gain_code = 2'h0;
        status_set = 8'h00;
        prox_raw = 8'h00;
        az_count = 8'h00;
        tick(8);
        rst = 1'b0;
        test_reset();
        test_gain();
        test_offset();
        test_irq();
        test_sleep();
        test_autozero();
        summarize();
    end
endmodule : tb_lscr_config_regs
